// ==== core/cpu_local_bus_interface.sv ====
// Overview of operation
// R1: external master owns bus; DMA or demand refresh request withdraws hold acknowledge.
// R2: external master finishes its cycle, then drops hold_request before handover.
// R3: priority: demand refresh, DMA, external hold, CPU, normal refresh.
// R4: shared pin carries int_ack_n, timer1_output or serial_ready_n per select.
// R5: external irqs synchronised, edge or level, prioritised; wake standby/emulation.
// R6: io_read_n low T2/T3/Tw for CPU io reads, DMA writes; not internal.
// R7: io_write_n low T2-Tw CPU writes, extended DMA reads; T3-Tw normal DMA reads.
// R8: mem_read_n low T2/T3/Tw of CPU reads, DMA reads and refresh.
// R9: mem_write_n low T2-Tw CPU writes, extended DMA writes; T3-Tw normal.
// R10: strobes and high_byte_enable_n float during hold acknowledge.
// R11: nmi accepted after five consecutive high clocks following a rising edge.
// R12: nmi serviced at instruction end via vector 2, beats irqs, wakes.
// R13: poll input sampled every five clocks until found low.
// R14: queue_state codes: nop, first byte, flush, subsequent byte.
// R15: each queue_state code is shown for exactly one clock.
// R16: ready low at T2 inserts Tw until ready high, then T4.
// R17: ready waits combine with programmed internal wait states.
// R18: refresh cycle drives refresh_strobe_n low and row on address bits 8..1.
// R19: reset held four clocks; leaves standby, native mode, restarts at ffff0.
// R20: reset_out is the reset, synchronised to clk.
// R21: byte lane encoding; odd word split into two cycles.
// R22: external clock source runs at twice the internal clock.
// R23: hold acknowledge asserted together with released bus outputs.
// R24: bus lock blocks DMA, refresh and external hold requests.
// R25: hold_request synchronised; grants only at bus cycle boundary.
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "local_bus_regs.svh"

module cpu_local_bus_interface import local_bus_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic cpu_req,
	input wire cyc_t cpu_cyc,
	input wire logic [19:0] cpu_addr,
	input wire logic cpu_word,
	input wire logic cpu_internal,
	input wire logic lock_out_n,
	output logic cpu_done,
	input wire logic dma_req,
	input wire logic dma_to_mem,
	input wire logic dma_extended,
	input wire logic [19:0] dma_addr,
	output logic dma_done,
	input wire logic refresh_req,
	input wire logic refresh_demand,
	output logic refresh_done,
	input wire logic hold_request,
	output logic hold_ack_n,
	input wire logic ready,
	output logic io_read_n,
	output logic io_write_n,
	output logic mem_read_n,
	output logic mem_write_n,
	output logic high_byte_enable_n,
	output logic bus_ctl_oe,
	output logic [19:0] addr_out,
	output logic refresh_strobe_n,
	input wire logic timer1_output,
	input wire logic serial_ready,
	output logic shared_pin,
	input wire logic [6:0] ext_irq_inputs,
	output logic irq_req,
	output logic [2:0] irq_level,
	input wire logic nonmaskable_irq,
	input wire logic instr_boundary,
	output logic nmi_take,
	output logic [7:0] service_vector,
	input wire logic enter_standby,
	input wire logic enter_emulation,
	output logic standby,
	output logic emulation,
	input wire logic poll_active,
	input wire logic poll_n,
	output logic poll_done,
	input wire logic queue_valid,
	input wire logic [1:0] queue_op,
	output logic [1:0] queue_state,
	input wire logic reset_pin,
	output logic reset_out,
	output logic cpu_restart,
	output logic [19:0] fetch_addr
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// strobe bits: {io_rd, io_wr, mem_rd, mem_wr}, active high
	function automatic logic [3:0] strobe_set(bus_state_t st, cyc_t cy, logic ext, logic intl);
		logic mid;
		logic late;
		logic [3:0] s;
		mid = (st == ST_T2) || (st == ST_T3) || (st == ST_TW);
		late = (st == ST_T3) || (st == ST_TW);
		s = 4'h0;
		case (cy)
			CYC_MEM_RD, CYC_REFRESH: s[1] = mid; // [R8]
			CYC_MEM_WR: s[0] = mid; // [R9]
			CYC_IO_RD: s[3] = mid && !intl; // [R6]
			CYC_IO_WR: s[2] = mid && !intl; // [R7]
			CYC_DMA_RD: begin
				s[1] = mid; // [R8]
				s[2] = ext ? mid : late; // [R7]
			end
			CYC_DMA_WR: begin
				s[3] = mid; // [R6]
				s[0] = ext ? mid : late; // [R9]
			end
			default: s = 4'h0;
		endcase
		return s;
	endfunction

	// lowest index wins
	function automatic logic [2:0] top_irq(logic [6:0] p);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 6; i >= 0; i--) begin
			if (p[i]) idx = 3'(i);
		end
		return idx;
	endfunction

	function automatic bus_if_state_t reset_state();
		bus_if_state_t r;
		r = '0;
		r.hbe_n = 1'b1;
		r.bus_oe = 1'b1;
		r.hold_ack_n = 1'b1;
		r.refresh_strobe_n = 1'b1;
		r.shared_pin = 1'b1;
		r.ctrl = `CTRL_RESET;
		r.avs_wait = 1'b1;
		r.fetch_addr = `RESTART_ADDR;
		return r;
	endfunction

	bus_if_state_t s_reg, s_next;
	logic hold_sync;
	logic [6:0] irq_sync;
	logic nmi_accept;
	logic reset_hold;

	pin_qualifier u_qual (
		.clk(clk),
		.rst(rst),
		.hold_request(hold_request),
		.nonmaskable_irq(nonmaskable_irq),
		.reset_pin(reset_pin),
		.ext_irq_inputs(ext_irq_inputs),
		.hold_sync(hold_sync),
		.irq_sync(irq_sync),
		.nmi_accept(nmi_accept),
		.reset_hold(reset_hold)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic locked;
		logic wr_ok;
		logic [6:0] irq_set;
		logic [6:0] irq_clr;
		logic [6:0] mode;
		locked = 1'b0;
		wr_ok = 1'b0;
		irq_set = 7'h0;
		irq_clr = 7'h0;
		mode = 7'h0;
		s_next = s_reg;
		s_next.done = 3'h0;
		locked = !lock_out_n;
		mode = s_reg.ctrl[`CTRL_IRQ_MODE_LSB +: 7];

		// bus cycle sequencer; arbitration only from idle [R25]
		case (s_reg.state)
			ST_IDLE: begin
				// idle for a cycle after done so the requester can drop req
				if (s_reg.done == 3'h0) begin
					if (s_reg.second_half) begin // [R21]
						s_next.state = ST_T1;
					end else if (!locked && refresh_req && refresh_demand) begin // [R3] [R24]
						s_next.state = ST_T1;
						s_next.owner = OWN_REFRESH;
						s_next.cyc = CYC_REFRESH;
					end else if (!locked && dma_req) begin // [R3] [R24]
						s_next.state = ST_T1;
						s_next.owner = OWN_DMA;
						s_next.cyc = dma_to_mem ? CYC_DMA_WR : CYC_DMA_RD;
						s_next.dma_ext = dma_extended;
						s_next.addr = dma_addr;
						s_next.hbe_n = !dma_addr[0]; // [R21]
					end else if (!locked && hold_sync) begin // [R3] [R24]
						s_next.state = ST_HOLD;
						s_next.owner = OWN_EXT;
						s_next.hold_ack_n = 1'b0; // [R23]
						s_next.bus_oe = 1'b0; // [R10]
					end else if (cpu_req) begin // [R3]
						s_next.state = ST_T1;
						s_next.owner = OWN_CPU;
						s_next.cyc = cpu_cyc;
						s_next.internal = cpu_internal;
						s_next.word = cpu_word;
						s_next.addr = cpu_addr;
						s_next.hbe_n = !(cpu_word || cpu_addr[0]); // [R21]
					end else if (!locked && refresh_req) begin // [R3]
						s_next.state = ST_T1;
						s_next.owner = OWN_REFRESH;
						s_next.cyc = CYC_REFRESH;
					end
					if (s_next.cyc == CYC_REFRESH && s_next.state == ST_T1) begin
						s_next.addr = {11'h0, s_reg.refresh_row, 1'b0}; // [R18]
						s_next.hbe_n = 1'b1;
					end
					if (s_next.state == ST_T1) begin
						s_next.wait_cnt = s_reg.ctrl[`CTRL_WAIT_LSB +: 2]; // [R17]
					end
				end
			end
			ST_T1: s_next.state = ST_T2;
			ST_T2: begin
				s_next.ready_t2 = ready; // [R16]
				s_next.state = ST_T3;
			end
			ST_T3: begin
				if (!s_reg.ready_t2 || s_reg.wait_cnt != 2'h0) begin // [R16] [R17]
					s_next.state = ST_TW;
				end else begin
					s_next.state = ST_T4;
				end
				if (s_reg.wait_cnt != 2'h0) s_next.wait_cnt = s_reg.wait_cnt - 2'h1;
			end
			ST_TW: begin
				// both the programmed count and ready must release the cycle
				if (ready && s_reg.wait_cnt == 2'h0) begin // [R16] [R17]
					s_next.state = ST_T4;
				end
				if (s_reg.wait_cnt != 2'h0) s_next.wait_cnt = s_reg.wait_cnt - 2'h1;
			end
			ST_T4: begin
				s_next.state = ST_IDLE;
				if (s_reg.owner == OWN_CPU && !s_reg.second_half && s_reg.word
						&& s_reg.addr[0]) begin
					s_next.second_half = 1'b1; // [R21]
					s_next.addr = s_reg.addr + 20'h1;
					s_next.hbe_n = 1'b1;
				end else begin
					s_next.second_half = 1'b0;
					s_next.done[s_reg.owner] = 1'b1;
					s_next.cyc = CYC_NONE;
				end
				if (s_reg.cyc == CYC_REFRESH) s_next.refresh_row = s_reg.refresh_row + 8'h1;
				if (s_reg.cyc == CYC_INTA && !s_next.second_half) begin
					irq_clr = 7'(7'h1 << s_reg.irq_level);
				end
			end
			ST_HOLD: begin
				if (!hold_sync) begin // [R2]
					s_next.state = ST_IDLE;
					s_next.owner = OWN_CPU;
					s_next.hold_ack_n = 1'b1;
					s_next.bus_oe = 1'b1;
				end else if (dma_req || (refresh_req && refresh_demand)) begin
					// withdraw acknowledge but keep floating until master lets go
					s_next.hold_ack_n = 1'b1; // [R1]
				end
			end
			default: s_next.state = ST_IDLE;
		endcase

		s_next.strobes = strobe_set(s_next.state, s_next.cyc, s_next.dma_ext,
			s_next.internal);
		s_next.refresh_strobe_n = !(s_next.cyc == CYC_REFRESH
			&& s_next.state != ST_IDLE && s_next.state != ST_HOLD); // [R18]

		// shared output pin
		case (s_reg.ctrl[`CTRL_PFS_LSB +: 2]) // [R4]
			`PFS_INT_ACK: s_next.shared_pin = !(s_next.cyc == CYC_INTA
				&& (s_next.state == ST_T2 || s_next.state == ST_T3
				|| s_next.state == ST_TW));
			`PFS_TIMER1: s_next.shared_pin = timer1_output;
			`PFS_SERIAL: s_next.shared_pin = !serial_ready;
			default: s_next.shared_pin = 1'b1;
		endcase

		// queue status lasts one clock per event
		s_next.queue_state = queue_valid ? queue_op : `QS_NOP; // [R14] [R15]

		// poll sampled every fifth clock
		s_next.poll_done = 1'b0;
		if (!poll_active) begin
			s_next.poll_cnt = 3'h0;
		end else begin
			if (s_reg.poll_cnt == 3'h0 && !poll_n) s_next.poll_done = 1'b1; // [R13]
			s_next.poll_cnt = (s_reg.poll_cnt == `POLL_INTERVAL - 3'h1) ? 3'h0
				: s_reg.poll_cnt + 3'h1;
		end

		// avalon slave: one wait cycle, then answer
		s_next.avs_wait = !((avs_read || avs_write) && s_reg.avs_wait);
		wr_ok = avs_write && !s_reg.avs_wait;
		if (avs_read && s_reg.avs_wait) begin
			if (avs_address == `CTRL_OFFSET) begin
				s_next.avs_rdata = {16'h0, s_reg.ctrl};
			end else if (avs_address == `STATUS_OFFSET) begin
				s_next.avs_rdata = {20'h0, s_reg.standby, s_reg.emulation,
					s_reg.nmi_pending, !s_reg.hold_ack_n, 1'b0, s_reg.state,
					2'h0, s_reg.owner};
			end else if (avs_address == `IRQ_OFFSET) begin
				s_next.avs_rdata = {25'h0, s_reg.irq_pending};
			end else begin
				s_next.avs_rdata = 32'h0;
			end
		end
		if (wr_ok && avs_address == `CTRL_OFFSET) begin
			s_next.ctrl = avs_writedata[15:0] & `CTRL_WRITE_MASK;
		end else if (wr_ok && avs_address == `IRQ_OFFSET) begin
			irq_clr = irq_clr | avs_writedata[6:0];
		end

		// interrupts: new set beats a same-cycle clear
		s_next.irq_prev = irq_sync;
		irq_set = (mode & irq_sync) | (~mode & irq_sync & ~s_reg.irq_prev); // [R5]
		s_next.irq_pending = (s_reg.irq_pending & ~irq_clr) | irq_set;
		s_next.irq_level = top_irq(s_next.irq_pending); // [R5]
		s_next.nmi_take = instr_boundary && s_reg.nmi_pending; // [R12]
		s_next.nmi_pending = nmi_accept || (s_reg.nmi_pending && !s_next.nmi_take);
		if (s_next.nmi_take) s_next.service_vector = `NMI_VECTOR; // [R12]
		s_next.irq_req = (|s_next.irq_pending) && !s_next.nmi_pending; // [R12]

		// low power and emulation modes
		if (enter_standby) s_next.standby = 1'b1;
		if (enter_emulation) s_next.emulation = 1'b1;
		if (nmi_accept || (|irq_set)) begin // [R5] [R12]
			s_next.standby = 1'b0;
			s_next.emulation = 1'b0;
		end

		// external reset
		s_next.reset_out = reset_hold; // [R20]
		s_next.restart = s_reg.reset_out && !reset_hold;
		if (reset_hold) begin // [R19]
			s_next.standby = 1'b0;
			s_next.emulation = 1'b0;
			s_next.fetch_addr = `RESTART_ADDR;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= reset_state();
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign avs_readdata = s_reg.avs_rdata;
	assign avs_waitrequest = s_reg.avs_wait;
	assign cpu_done = s_reg.done[OWN_CPU];
	assign dma_done = s_reg.done[OWN_DMA];
	assign refresh_done = s_reg.done[OWN_REFRESH];
	assign hold_ack_n = s_reg.hold_ack_n;
	assign io_read_n = !s_reg.strobes[3];
	assign io_write_n = !s_reg.strobes[2];
	assign mem_read_n = !s_reg.strobes[1];
	assign mem_write_n = !s_reg.strobes[0];
	assign high_byte_enable_n = s_reg.hbe_n;
	assign bus_ctl_oe = s_reg.bus_oe;
	assign addr_out = s_reg.addr;
	assign refresh_strobe_n = s_reg.refresh_strobe_n;
	assign shared_pin = s_reg.shared_pin;
	assign irq_req = s_reg.irq_req;
	assign irq_level = s_reg.irq_level;
	assign nmi_take = s_reg.nmi_take;
	assign service_vector = s_reg.service_vector;
	assign standby = s_reg.standby;
	assign emulation = s_reg.emulation;
	assign poll_done = s_reg.poll_done;
	assign queue_state = s_reg.queue_state;
	assign reset_out = s_reg.reset_out;
	assign cpu_restart = s_reg.restart;
	assign fetch_addr = s_reg.fetch_addr;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_demand_over_dma: assert property ( // [R3]
		(s_reg.state == ST_IDLE && s_reg.done == 3'h0 && !s_reg.second_half && lock_out_n
			&& refresh_req && refresh_demand && dma_req)
		|=> s_reg.state == ST_T1 && s_reg.owner == OWN_REFRESH)
		else $error("demand refresh lost to another requester");
	a_lock_blocks_hold: assert property ( // [R24]
		(s_reg.state == ST_IDLE && !lock_out_n) |=> s_reg.state != ST_HOLD && s_reg.hold_ack_n)
		else $error("hold granted while bus locked");
	a_hold_float: assert property ( // [R10]
		$fell(s_reg.hold_ack_n) |-> $fell(s_reg.bus_oe) && io_read_n && mem_write_n)
		else $error("hold acknowledge without released outputs");
	a_hold_reclaim: assert property ( // [R1]
		(s_reg.state == ST_HOLD && hold_sync && dma_req) |=> s_reg.hold_ack_n && !s_reg.bus_oe)
		else $error("hold not withdrawn for dma request");
	a_dma_normal_rd: assert property ( // [R7]
		(s_reg.cyc == CYC_DMA_RD && !s_reg.dma_ext && s_reg.state == ST_T2)
		|-> !mem_read_n && io_write_n ##1 !io_write_n && !mem_read_n)
		else $error("normal dma read strobes wrong");
	a_refresh_strobes: assert property ( // [R8]
		(s_reg.cyc == CYC_REFRESH && s_reg.state == ST_T2)
		|-> !mem_read_n && !refresh_strobe_n && s_reg.addr[0] == 1'b0) // [R18]
		else $error("refresh cycle strobes wrong");
	a_ready_wait: assert property ( // [R16]
		(s_reg.state == ST_T3 && !s_reg.ready_t2) |=> s_reg.state == ST_TW)
		else $error("ready wait not inserted");
	a_wait_until_ready: assert property ( // [R16] [R17]
		s_reg.state == ST_TW |=> (s_reg.state == ST_T4)
			== ($past(ready) && $past(s_reg.wait_cnt) == 2'h0))
		else $error("wait state ended at the wrong time");
	a_queue_pulse: assert property ( // [R15]
		(queue_valid && queue_op != `QS_NOP) ##1 !queue_valid
		|-> queue_state == $past(queue_op) ##1 queue_state == `QS_NOP)
		else $error("queue status not one clock");
	a_poll_interval: assert property ( // [R13]
		s_reg.poll_done |-> $past(s_reg.poll_cnt) == 3'h0 && $past(poll_active))
		else $error("poll sampled off interval");
	a_nmi_over_irq: assert property ( // [R12]
		s_reg.nmi_pending |-> (!s_reg.irq_req) and (instr_boundary |=> s_reg.nmi_take
			&& s_reg.service_vector == `NMI_VECTOR))
		else $error("nmi priority or vector wrong");
	a_reset_out_follow: assert property ( // [R20]
		reset_hold |=> s_reg.reset_out && !s_reg.standby && !s_reg.emulation)
		else $error("reset output not following reset");

	c_refresh_cycle: cover property (s_reg.done[OWN_REFRESH]);
	c_hold_grant: cover property ($fell(s_reg.hold_ack_n));
	c_odd_word_split: cover property ($rose(s_reg.second_half));
	c_nmi_taken: cover property (s_reg.nmi_take);

endmodule // cpu_local_bus_interface

// ==== core/local_bus_pkg.sv ====
package local_bus_pkg;

	typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4, ST_HOLD} bus_state_t;

	typedef enum logic [1:0] {OWN_CPU, OWN_DMA, OWN_REFRESH, OWN_EXT} owner_t;

	typedef enum logic [3:0] {
		CYC_NONE, CYC_MEM_RD, CYC_MEM_WR, CYC_IO_RD, CYC_IO_WR,
		CYC_INTA, CYC_REFRESH, CYC_DMA_RD, CYC_DMA_WR
	} cyc_t;

	typedef struct packed {
		logic [9:0] meta;
		logic [9:0] sync;
		logic [2:0] nmi_cnt;
		logic nmi_accept;
		logic [2:0] rst_cnt;
		logic reset_hold;
	} qual_state_t;

	typedef struct packed {
		bus_state_t state;
		owner_t owner;
		cyc_t cyc;
		logic dma_ext;
		logic internal;
		logic word;
		logic second_half;
		logic [19:0] addr;
		logic hbe_n;
		logic [1:0] wait_cnt;
		logic ready_t2;
		logic [3:0] strobes;
		logic bus_oe;
		logic hold_ack_n;
		logic refresh_strobe_n;
		logic [7:0] refresh_row;
		logic shared_pin;
		logic [2:0] done;
		logic [1:0] queue_state;
		logic [6:0] irq_prev;
		logic [6:0] irq_pending;
		logic irq_req;
		logic [2:0] irq_level;
		logic nmi_pending;
		logic nmi_take;
		logic [7:0] service_vector;
		logic standby;
		logic emulation;
		logic [2:0] poll_cnt;
		logic poll_done;
		logic reset_out;
		logic restart;
		logic [19:0] fetch_addr;
		logic [15:0] ctrl;
		logic avs_wait;
		logic [31:0] avs_rdata;
	} bus_if_state_t;

endpackage

// ==== core/local_bus_regs.svh ====
`ifndef LOCAL_BUS_REGS_SVH
`define LOCAL_BUS_REGS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define CTRL_OFFSET 4'h0
`define STATUS_OFFSET 4'h4
`define IRQ_OFFSET 4'h8

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_PFS_LSB 0
`define CTRL_WAIT_LSB 2
`define CTRL_IRQ_MODE_LSB 8
`define CTRL_WRITE_MASK 16'h7f0f
`define CTRL_RESET 16'h0000

// ----------------------------------------
// pin function select codes
// ----------------------------------------
`define PFS_INT_ACK 2'h0
`define PFS_TIMER1 2'h1
`define PFS_SERIAL 2'h2

// ----------------------------------------
// queue status codes
// ----------------------------------------
`define QS_NOP 2'h0
`define QS_FIRST 2'h1
`define QS_FLUSH 2'h2
`define QS_NEXT 2'h3

// ----------------------------------------
// timing counts, in clk cycles
// ----------------------------------------
`define NMI_MIN_CLOCKS 3'h5
`define RESET_MIN_CLOCKS 3'h4
`define POLL_INTERVAL 3'h5

// ----------------------------------------
// vectors and addresses
// ----------------------------------------
`define NMI_VECTOR 8'h02
`define RESTART_ADDR 20'hffff0

`endif

// ==== core/pin_qualifier.sv ====
`timescale 1ns/1ps
`include "local_bus_regs.svh"

module pin_qualifier import local_bus_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic hold_request,
	input wire logic nonmaskable_irq,
	input wire logic reset_pin,
	input wire logic [6:0] ext_irq_inputs,
	output logic hold_sync,
	output logic [6:0] irq_sync,
	output logic nmi_accept,
	output logic reset_hold
);
	qual_state_t s_reg, s_next;
	logic nmi_s;
	logic rst_s;

	assign nmi_s = s_reg.sync[8];
	assign rst_s = s_reg.sync[7];

	always_comb begin
		s_next = s_reg;
		// second stage only ever reads the first
		s_next.meta = {hold_request, nonmaskable_irq, reset_pin, ext_irq_inputs}; // [R25] [R5]
		s_next.sync = s_reg.meta;
		s_next.nmi_accept = 1'b0;
		if (!nmi_s) begin
			s_next.nmi_cnt = 3'h0;
		end else if (s_reg.nmi_cnt != `NMI_MIN_CLOCKS) begin
			s_next.nmi_cnt = s_reg.nmi_cnt + 3'h1;
			// one pulse per rising edge, saturating count blocks refire
			s_next.nmi_accept = (s_reg.nmi_cnt == `NMI_MIN_CLOCKS - 3'h1); // [R11]
		end
		if (!rst_s) begin
			s_next.rst_cnt = 3'h0;
		end else if (s_reg.rst_cnt != `RESET_MIN_CLOCKS) begin
			s_next.rst_cnt = s_reg.rst_cnt + 3'h1;
		end
		s_next.reset_hold = rst_s && (s_reg.rst_cnt >= `RESET_MIN_CLOCKS - 3'h1); // [R19]
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hold_sync = s_reg.sync[9];
	assign irq_sync = s_reg.sync[6:0];
	assign nmi_accept = s_reg.nmi_accept;
	assign reset_hold = s_reg.reset_hold;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_nmi_five_cycles: assert property (@(posedge clk) disable iff (rst) // [R11]
		$rose(nmi_s) ##0 nmi_s [*5] |=> s_reg.nmi_accept)
		else $error("nmi not accepted after five high cycles");
	a_reset_min_clocks: assert property (@(posedge clk) disable iff (rst) // [R19]
		$rose(s_reg.reset_hold) |-> $past(rst_s, 1) && $past(rst_s, 2)
			&& $past(rst_s, 3) && $past(rst_s, 4))
		else $error("reset recognised before four clocks");

endmodule // pin_qualifier

// ==== verification/bus_partner.sv ====
`timescale 1ns/1ps

module bus_partner (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic hold_go,
	input wire logic [3:0] strobe_n,
	input wire logic hold_ack_n,
	output logic ready,
	output logic hold_request
);
	// ------------------------------
	// slow device and external master
	// ------------------------------
	logic [2:0] wait_reg;
	logic seen_reg;

	// counts strobe cycles; a slow device holds ready low from before the end of t2
	always_ff @(posedge clk) begin
		if (rst || &strobe_n) wait_reg <= 3'h0;
		else if (wait_reg != 3'h7) wait_reg <= wait_reg + 3'h1;
	end
	assign ready = !slow || wait_reg >= 3'h4;

	// master has no cycle in flight, so it lets go one clock after losing the grant
	always_ff @(posedge clk) begin
		if (rst || !hold_go) seen_reg <= 1'b0;
		else if (!hold_ack_n) seen_reg <= 1'b1;
		hold_request <= !rst && hold_go && !(seen_reg && hold_ack_n);
	end
endmodule // bus_partner

// ==== verification/testbench.sv ====
`timescale 1ns/1ps

module testbench import local_bus_pkg::*;;
	logic clk = 0, rst = 1, slow = 0, hold_go = 0, ready, hold_request;
	logic [3:0] avs_address = '0;
	logic avs_read = 0, avs_write = 0;
	logic [31:0] avs_writedata = '0, avs_readdata, q;
	logic avs_waitrequest, cpu_done, dma_done, refresh_done, hold_ack_n, bus_ctl_oe;
	logic io_read_n, io_write_n, mem_read_n, mem_write_n, high_byte_enable_n, refresh_strobe_n;
	logic shared_pin, irq_req, nmi_take, standby, emulation, poll_done, reset_out, cpu_restart;
	logic [19:0] addr_out, fetch_addr, cpu_addr = 20'h00100, dma_addr = 20'h00200;
	logic [2:0] irq_level;
	logic [7:0] service_vector;
	logic [1:0] queue_state, queue_op = '0;
	cyc_t cpu_cyc = CYC_NONE;
	logic cpu_req = 0, cpu_word = 0, cpu_internal = 0, lock_out_n = 1, dma_req = 0;
	logic dma_to_mem = 0, dma_extended = 0, refresh_req = 0, refresh_demand = 0;
	logic timer1_output = 0, serial_ready = 0, nonmaskable_irq = 0, instr_boundary = 0;
	logic enter_standby = 0, enter_emulation = 0, poll_active = 0, poll_n = 1;
	logic queue_valid = 0, reset_pin = 0;
	logic [6:0] ext_irq_inputs = '0;
	int err_count = 0, checks = 0, cycles = 0, lo[6];
	wire [5:0] strb = {shared_pin, refresh_strobe_n, mem_write_n, mem_read_n,
		io_write_n, io_read_n};

	cpu_local_bus_interface cpu_local_bus_interface_i (.*);
	bus_partner bus_partner_i (.clk(clk), .rst(rst), .slow(slow), .hold_go(hold_go),
		.strobe_n({io_read_n, io_write_n, mem_read_n, mem_write_n}),
		.hold_ack_n(hold_ack_n), .ready(ready), .hold_request(hold_request));

	// internal clock; its source runs at twice this rate
	always #50 clk = ~clk;

	// ------------------------------
	// tasks
	// ------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// request held until the edge that samples waitrequest low; idle edge after release
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	// counts low cycles of each strobe up to the done pulse
	task automatic xfer();
		lo = '{default: 0};
		do begin
			@(negedge clk);
			foreach (lo[i]) lo[i] += int'(strb[i] === 1'b0);
		end while ((cpu_done | dma_done | refresh_done) !== 1'b1);
		@(posedge clk);
		cpu_req <= 1'b0;
		dma_req <= 1'b0;
		refresh_req <= 1'b0;
		@(posedge clk);
	endtask

	task automatic cpu(input cyc_t c, input logic intl, input int idx, input int exp);
		cpu_cyc <= c;
		cpu_internal <= intl;
		cpu_req <= 1'b1;
		xfer();
		chk(c.name(), lo[idx], exp);
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			finish_test();
		end
	end

	// ------------------------------
	// sequence
	// ------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		av(0, 4'h0, '0); chk("ctrl_reset", q, 32'h0);
		av(1, 4'h0, 32'hffffffff);
		av(0, 4'h0, '0); chk("ctrl_mask", q, 32'h00007f0f);
		av(1, 4'hc, 32'hffffffff);
		av(0, 4'hc, '0); chk("unmapped", q, 32'h0);
		cpu(CYC_IO_RD, 0, 0, 5);
		av(1, 4'h0, 32'h1);
		repeat (3) @(negedge clk); chk("pin_timer", shared_pin, 1'b0);
		@(posedge clk);
		av(1, 4'h0, 32'h2);
		timer1_output <= 1'b1;
		serial_ready <= 1'b1;
		repeat (3) @(negedge clk); chk("pin_serial", shared_pin, 1'b0);
		@(posedge clk);
		av(1, 4'h0, 32'h0);
		$display("registers done");
		cpu(CYC_IO_RD, 0, 0, 2);
		cpu(CYC_IO_RD, 1, 0, 0);
		cpu(CYC_IO_WR, 1, 1, 0);
		cpu(CYC_IO_WR, 0, 1, 2);
		cpu(CYC_MEM_RD, 0, 2, 2);
		cpu(CYC_MEM_WR, 0, 3, 2);
		cpu(CYC_INTA, 0, 5, 2);
		slow <= 1'b1;
		cpu(CYC_MEM_RD, 0, 2, 5);
		slow <= 1'b0;
		lock_out_n <= 1'b0;
		dma_req <= 1'b1;
		cpu(CYC_MEM_WR, 0, 3, 2);
		lock_out_n <= 1'b1;
		cpu_word <= 1'b1;
		cpu_addr <= 20'h00101;
		cpu(CYC_MEM_RD, 0, 2, 4);
		for (int k = 0; k < 4; k++) begin
			dma_to_mem <= k[1];
			dma_extended <= k[0];
			dma_req <= 1'b1;
			xfer();
			chk("dma_read_side", lo[k[1] ? 0 : 2], 2);
			chk("dma_write_side", lo[k[1] ? 3 : 1], k[0] ? 2 : 1);
		end
		refresh_req <= 1'b1;
		xfer();
		chk("refresh_mrd", lo[2], 2);
		chk("refresh_strobe", lo[4], 4);
		refresh_demand <= 1'b1;
		refresh_req <= 1'b1;
		dma_req <= 1'b1;
		xfer();
		chk("demand_first", lo[4], 4);
		chk("refresh_row", {high_byte_enable_n, addr_out}, 21'h100002);
		refresh_demand <= 1'b0;
		$display("bus cycles done");
		hold_go <= 1'b1;
		do @(negedge clk); while (hold_ack_n !== 1'b0);
		chk("hold_float", bus_ctl_oe, 1'b0);
		@(posedge clk);
		dma_to_mem <= 1'b0;
		dma_req <= 1'b1;
		xfer();
		chk("reclaim_ack", hold_ack_n, 1'b1);
		chk("reclaim_oe", bus_ctl_oe, 1'b1);
		hold_go <= 1'b0;
		$display("hold done");
		for (int k = 0; k < 4; k++) begin
			queue_op <= k[1:0];
			queue_valid <= 1'b1;
			@(posedge clk);
			queue_valid <= 1'b0;
			@(negedge clk); chk("queue_code", queue_state, k[1:0]);
			@(negedge clk); chk("queue_gap", queue_state, 2'h0);
			@(posedge clk);
		end
		ext_irq_inputs <= 7'h04;
		repeat (4) @(negedge clk); chk("irq_level", {irq_req, irq_level}, 4'ha);
		@(posedge clk);
		nonmaskable_irq <= 1'b1;
		repeat (10) @(posedge clk);
		instr_boundary <= 1'b1;
		@(posedge clk);
		instr_boundary <= 1'b0;
		@(negedge clk); chk("nmi_take", nmi_take, 1'b1);
		chk("nmi_vector", service_vector, 8'h02);
		@(posedge clk);
		poll_n <= 1'b0;
		poll_active <= 1'b1;
		repeat (2) @(negedge clk); chk("poll_hit", poll_done, 1'b1);
		@(negedge clk); chk("poll_gap", poll_done, 1'b0);
		@(posedge clk);
		poll_active <= 1'b0;
		reset_pin <= 1'b1;
		enter_standby <= 1'b1;
		@(posedge clk);
		enter_standby <= 1'b0;
		repeat (8) @(negedge clk); chk("reset_out", reset_out, 1'b1);
		chk("standby_left", standby, 1'b0);
		@(posedge clk);
		reset_pin <= 1'b0;
		do @(negedge clk); while (cpu_restart !== 1'b1);
		chk("restart_addr", fetch_addr, 20'hffff0);
		$display("interrupt, poll and reset done");
		finish_test();
	end
endmodule // testbench
